// ### sim/timer8_core_assertions.sv
// Port-level assertions and covers for the 8-bit timer core
`timescale 1ns/1ps
`default_nettype none
module timer8_core_assertions (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        external_count_pin,
  input wire logic        timer_irq,
  input wire logic        async_prescaler_reset,
  input wire logic        at_bottom,
  input wire logic        at_max,
  input wire logic        at_top
);
  // --------------------------------------------------------------
  // Bus decode helpers
  // --------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Access phase qualifiers; map ends at the mask register
  wire logic acc    = psel && penable;
  wire logic wr_acc = acc && pwrite;
  wire logic rd_acc = acc && !pwrite;
  wire logic mapped  = (paddr <= 12'h014) && (paddr[1:0] == 2'b00);
  wire logic wr_sync = wr_acc && (paddr == 12'h000);
  wire logic wr_cnt  = wr_acc && (paddr == 12'h008);

  a_zero_wait: assert property (acc |-> pready)
    else $error("access phase without ready");
  a_slverr_map: assert property (pslverr == (acc && !mapped))
    else $error("error response does not match address map");
  a_upper_zero: assert property (rd_acc |-> prdata[31:8] == 24'h00_0000)
    else $error("read data above byte width not zero");
  a_reserved_zero: assert property (rd_acc && paddr == 12'h000 |-> prdata[6:2] == 5'h00)
    else $error("reserved sync control bits read nonzero");
  // The held reset stays visible on the pin once the write lands
  a_hold_kept: assert property (wr_sync && pwdata[7] && pwdata[1] |=> async_prescaler_reset)
    else $error("held prescaler reset not kept");
  a_hold_release: assert property (wr_sync && !pwdata[7] |=> !async_prescaler_reset || wr_sync)
    else $error("prescaler reset not cleared on release");
  // Counter writes win over any count at the same edge
  a_write_bottom: assert property (wr_cnt |=> at_bottom == ($past(pwdata[7:0]) == 8'h00))
    else $error("bottom level wrong after counter write");
  a_write_max: assert property (wr_cnt |=> at_max == ($past(pwdata[7:0]) == 8'hFF))
    else $error("max level wrong after counter write");
  a_bottom_max: assert property (!(at_bottom && at_max))
    else $error("bottom and max both high");
  // Read data must not move in the cycle after its access phase
  a_rdata_hold: assert property (rd_acc |=> $stable(prdata))
    else $error("read data changed after access");
  a_mask_gate: assert property (wr_acc && paddr == 12'h014 && pwdata[1:0] == 2'b00 |=> !timer_irq)
    else $error("interrupt high with every mask bit clear");
  c_hold: cover property (wr_sync && pwdata[7]);
  c_max: cover property (at_max);
  c_irq: cover property (timer_irq);
  c_top: cover property (at_top && !at_max);
endmodule
bind timer8_core timer8_core_assertions chk (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .external_count_pin(external_count_pin), .timer_irq(timer_irq), .async_prescaler_reset(async_prescaler_reset),
  .at_bottom(at_bottom), .at_max(at_max), .at_top(at_top));
`default_nettype wire

// ### sim/timer8_counter_prescaler_sync_tb.sv
// Self-checking bench for the 8-bit timer core over APB
`timescale 1ns/1ps
`default_nettype none
`include "timer8_defines.vh"
module timer8_counter_prescaler_sync_tb;
  localparam [11:0] SYNC = `ADDR_SYNC_CONTROL;
  localparam [11:0] TCTL = `ADDR_TIMER_CONTROL;
  localparam [11:0] CNT  = `ADDR_COUNTER_VALUE;
  logic             ref_clk, rst, psel, penable, pwrite, external_count_pin, err;
  logic      [11:0] paddr;
  logic      [31:0] pwdata, rd;
  wire logic        pready, pslverr, timer_irq, async_prescaler_reset, at_bottom, at_max, at_top;
  wire logic [31:0] prdata;
  integer           n_mismatch = 0, checks = 0, seed = 26242, cyc = 0, cs, t, k, nn, a;
  logic       [7:0] x, c, msk;
  logic       [1:0] m;
  logic       [9:0] e;

  timer8_core dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .external_count_pin(external_count_pin), .timer_irq(timer_irq),
    .async_prescaler_reset(async_prescaler_reset), .at_bottom(at_bottom), .at_max(at_max), .at_top(at_top));

  // --------------------------------------------------------------
  // Clock, watchdog, reporting
  // --------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // The prescaled trials dominate at under twenty thousand cycles; this ceiling leaves ample room
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      final_report;
    end
  end
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk({31'h0000_0000, got}, {31'h0000_0000, exp});
  endtask
  // One APB transfer; the request holds until pready is seen high
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // Ready is looked at on every access edge; only the watchdog ends a hang
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d);
  endtask
  task automatic rdchk(input logic [11:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0000_0000);
    chk(rd, exp);
  endtask
  // Counter and flags after kk ticks; the first tick after a counter write cannot match
  function automatic [9:0] model(input logic [7:0] v0, input logic [7:0] cv, input logic [1:0] md, input integer kk);
    logic [7:0] v;
    logic [1:0] f;
    v = v0;
    f = 2'b00;
    for (int i = 0; i < kk; i++) begin
      if (i > 0 && v == cv) f[1] = 1'b1;
      if (md == 2'h2 && i > 0 && v == cv) {f[0], v} = {1'b1, 8'h00};
      else v = v + 8'h01;
      if (md != 2'h2 && v == 8'h00) f[0] = 1'b1;
    end
    model = {f, v};
  endfunction

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata, external_count_pin} = {1'b1, 48'h0000_0000_0000};
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    for (a = 0; a <= 20; a += 4) rdchk(12'(a), 32'h0000_0000);
    chk_bit(at_bottom, 1'b1);
    chk_bit(at_top, 1'b0);
    rdchk(12'h018, 32'h0000_0000);
    chk_bit(err, 1'b1);
    wr(SYNC, 32'h0000_007C);
    rdchk(SYNC, 32'h0000_0000);
    wr(SYNC, 32'h0000_0001);
    rdchk(SYNC, 32'h0000_0000);
    wr(SYNC, 32'h0000_0083);
    rdchk(SYNC, 32'h0000_0083);
    wr(SYNC, 32'h0000_0000);
    rdchk(SYNC, 32'h0000_0000);
    x = 8'($random(seed));
    wr(TCTL, 32'h0000_0000);
    wr(CNT, {24'h00_0000, x});
    repeat (20) @(posedge ref_clk);
    rdchk(CNT, {24'h00_0000, x});
    // Direct clock: counts at each of the three edges up to the stop write
    wr(TCTL, 32'h0000_0004);
    wr(CNT, 32'h0000_00FF);
    wr(CNT, 32'h0000_0000);
    wr(TCTL, 32'h0000_0000);
    rdchk(CNT, 32'h0000_0003);
    // Prescaled runs gated by the sync hold so the tick count is known
    for (cs = 2; cs <= 5; cs++) for (t = 0; t < 3; t++) begin
      nn = (cs == 2) ? 8 : (cs == 3) ? 64 : (cs == 4) ? 256 : 1024;
      m = 2'($random(seed));
      k = 1 + ($unsigned($random(seed)) % 3);
      x = 8'($random(seed));
      c = 8'($random(seed));
      msk = 8'($random(seed)) & 8'h03;
      if (m == 2'h2) begin
        x = x & 8'h7F;
        c = x + 8'h01 + (c & 8'h3F);
      end else if (c == x) c = x ^ 8'h01;
      wr(SYNC, 32'h0000_0081);
      wr(TCTL, {27'h000_0000, 3'(cs), m});
      wr(`ADDR_COMPARE_VALUE, {24'h00_0000, c});
      wr(CNT, {24'h00_0000, x});
      wr(`ADDR_IRQ_FLAGS, 32'h0000_0003);
      wr(`ADDR_IRQ_MASK, {24'h00_0000, msk});
      wr(SYNC, 32'h0000_0000);
      repeat (nn * k + nn / 2 - 3) @(posedge ref_clk);
      wr(SYNC, 32'h0000_0081);
      e = model(x, c, m, k);
      rdchk(CNT, {24'h00_0000, e[7:0]});
      rdchk(`ADDR_IRQ_FLAGS, {30'h0000_0000, e[9:8]});
      chk_bit(timer_irq, |(e[9:8] & msk[1:0]));
      chk_bit(at_top, (m == 2'h2) ? (e[7:0] == c) : (e[7:0] == 8'hFF));
    end
    // A shared reset pulse outside hold moves the next divide-by-8 tick late, so none lands
    wr(TCTL, 32'h0000_0008);
    wr(CNT, 32'h0000_0000);
    wr(SYNC, 32'h0000_0000);
    repeat (3) @(posedge ref_clk);
    wr(SYNC, 32'h0000_0001);
    wr(SYNC, 32'h0000_0081);
    rdchk(CNT, 32'h0000_0000);
    wr(SYNC, 32'h0000_0000);
    // External pin: each pulse gives one rising and one falling edge
    for (cs = 6; cs <= 7; cs++) begin
      wr(TCTL, {27'h000_0000, 3'(cs), 2'b00});
      wr(CNT, 32'h0000_0000);
      k = 1 + ($unsigned($random(seed)) % 5);
      repeat (k) begin
        external_count_pin <= 1'b1;
        repeat (4) @(posedge ref_clk);
        external_count_pin <= 1'b0;
        repeat (4) @(posedge ref_clk);
      end
      repeat (5) @(posedge ref_clk);
      rdchk(CNT, 32'(k));
    end
    // Reset again from a busy state: every register returns to zero
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    for (a = 0; a <= 20; a += 4) rdchk(12'(a), 32'h0000_0000);
    final_report;
  end
endmodule
`default_nettype wire

// ### verilog/prescaler10.v
// Free-running 10-bit prescaler with synchronous reset and divided tick outputs
`timescale 1ns/1ps
`default_nettype none
`include "timer8_defines.vh"

module prescaler10 (
  input  wire       ref_clk,
  input  wire       rst,
  input  wire       hold,
  output wire       tick_8,
  output wire       tick_64,
  output wire       tick_256,
  output wire       tick_1024
);

  reg [`PRESCALE_WIDTH-1:0] count_q;

  // ----------------------------------------------------------------
  // Counter: held at zero while the prescaler reset is asserted
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (rst || hold) begin
      count_q <= {`PRESCALE_WIDTH{1'b0}};
    end else begin
      count_q <= count_q + 10'h001;
    end
  end

  // Ticks fire on the last count of each period, so a halt gives none
  assign tick_8    = !hold && (count_q[2:0] == 3'h7);
  assign tick_64   = !hold && (count_q[5:0] == 6'h3F);
  assign tick_256  = !hold && (count_q[7:0] == 8'hFF);
  assign tick_1024 = !hold && (count_q == 10'h3FF);

endmodule
`default_nettype wire

// ### verilog/timer8_core.v
// 8-bit timer/counter core with shared prescaler control and APB register slave
//
// Functional notes
// - Sync-hold bit set keeps written prescaler-reset bits, halting affected timers.
// - Writing sync-hold to zero clears both prescaler-reset bits in hardware.
// - Shared prescaler-reset bit resets common prescaler; self-clears unless sync-hold.
// - Counter value and compare value registers are 8 bits wide.
// - Each interrupt flag is gated by its own mask bit.
// - Timer clock comes from prescaler or external pin, with edge choice.
// - Clock-select zero stops the counter.
// - Counter is compared with compare value continuously; match sets compare flag.
// - Bottom indication asserted when the counter becomes 0x00.
// - Maximum indication asserted when the counter becomes 0xFF.
// - Top is 0xFF or the compare value, chosen by mode.
// - Each timer clock clears, increments or decrements the counter by one; this design only clears or increments it.
// - Clear forces every counter bit to zero.
// - Processor reads and writes counter regardless of timer clock.
// - Processor counter write beats a simultaneous clear or count.
// - Two waveform-mode bits select the counting sequence.
// - Overflow flag set where the selected mode defines overflow.
// - Clock-select 1 direct; 2..5 select divide by 8, 64, 256, 1024.
// - Clock-select 7 rising, 6 falling external edges; one pulse each.
// - Mode 0 counts up, wraps 0xFF to 0x00, overflow when zero.
// - Mode 2 clears on compare match; compare value is the top.
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "timer8_defines.vh"

module timer8_core (
  input  wire        ref_clk,
  input  wire        rst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // Pins and status
  input  wire        external_count_pin,
  output wire        timer_irq,
  output wire        async_prescaler_reset,
  output wire        at_bottom,
  output wire        at_max,
  output wire        at_top
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  reg        sync_hold_mode_q;
  reg        async_psr_q;
  reg        shared_psr_q;
  reg  [4:0] timer_control_q;   // clock_select in [4:2], waveform_mode in [1:0]
  reg  [7:0] counter_value_q;
  reg  [7:0] compare_value_q;
  reg  [1:0] irq_flags_q;
  reg  [1:0] irq_mask_q;
  reg        block_match_q;     // Counter write blocks the compare flag at the next timer clock
  reg        ext_meta_q;
  reg        ext_sync_q;
  reg        ext_prev_q;

  wire [2:0] clock_select  = timer_control_q[`CLKSEL_MSB:`CLKSEL_LSB];
  wire [1:0] waveform_mode = timer_control_q[`WAVE_HI_BIT:`WAVE_LO_BIT];

  // ----------------------------------------------------------------
  // APB decode: zero-wait slave, writes take effect in access, read data is captured in setup
  // ----------------------------------------------------------------
  wire access   = psel && penable;
  wire wr_en    = access && pwrite;
  wire addr_ok  = (paddr == `ADDR_SYNC_CONTROL) || (paddr == `ADDR_TIMER_CONTROL) ||
                  (paddr == `ADDR_COUNTER_VALUE) || (paddr == `ADDR_COMPARE_VALUE) ||
                  (paddr == `ADDR_IRQ_FLAGS) || (paddr == `ADDR_IRQ_MASK);
  wire wr_sync  = wr_en && (paddr == `ADDR_SYNC_CONTROL);
  wire wr_ctrl  = wr_en && (paddr == `ADDR_TIMER_CONTROL);
  wire wr_cnt   = wr_en && (paddr == `ADDR_COUNTER_VALUE);
  wire wr_cmp   = wr_en && (paddr == `ADDR_COMPARE_VALUE);
  wire wr_flags = wr_en && (paddr == `ADDR_IRQ_FLAGS);
  wire wr_mask  = wr_en && (paddr == `ADDR_IRQ_MASK);

  assign pready  = 1'b1;
  assign pslverr = access && !addr_ok;   // Unmapped addresses answer with an error

  // ----------------------------------------------------------------
  // Sync control: hold mode keeps the reset bits, otherwise they pulse
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (rst) begin
      sync_hold_mode_q <= 1'b0;
      async_psr_q      <= 1'b0;
      shared_psr_q     <= 1'b0;
    end else if (wr_sync) begin
      sync_hold_mode_q <= pwdata[`SYNC_HOLD_BIT];
      if (pwdata[`SYNC_HOLD_BIT]) begin
        async_psr_q  <= pwdata[`ASYNC_PSR_BIT];
        shared_psr_q <= pwdata[`SHARED_PSR_BIT];
      end else begin
        // Leaving hold releases every timer in the same cycle
        async_psr_q  <= 1'b0;
        shared_psr_q <= 1'b0;
      end
    end else if (!sync_hold_mode_q) begin
      async_psr_q  <= 1'b0;
      shared_psr_q <= 1'b0;
    end
  end

  // A one written outside hold mode still resets the prescaler that cycle
  wire shared_reset_now = shared_psr_q || (wr_sync && pwdata[`SHARED_PSR_BIT]);
  assign async_prescaler_reset = async_psr_q || (wr_sync && pwdata[`ASYNC_PSR_BIT]);

  // ----------------------------------------------------------------
  // Shared prescaler
  // ----------------------------------------------------------------
  wire tick_8;
  wire tick_64;
  wire tick_256;
  wire tick_1024;

  prescaler10 u_prescaler (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .hold      (shared_reset_now),
    .tick_8    (tick_8),
    .tick_64   (tick_64),
    .tick_256  (tick_256),
    .tick_1024 (tick_1024)
  );

  // ----------------------------------------------------------------
  // External pin: two-flop synchroniser, then edge detector
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (rst) begin
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      ext_meta_q <= external_count_pin;
      ext_sync_q <= ext_meta_q;
      ext_prev_q <= ext_sync_q;
    end
  end

  wire ext_rise = ext_sync_q && !ext_prev_q;
  wire ext_fall = !ext_sync_q && ext_prev_q;

  // ----------------------------------------------------------------
  // Clock select: one-cycle timer clock enable
  // ----------------------------------------------------------------
  reg timer_clock;
  always @* begin
    case (clock_select)
      `CS_STOP:     timer_clock = 1'b0;
      `CS_DIRECT:   timer_clock = 1'b1;
      `CS_DIV8:     timer_clock = tick_8;
      `CS_DIV64:    timer_clock = tick_64;
      `CS_DIV256:   timer_clock = tick_256;
      `CS_DIV1024:  timer_clock = tick_1024;
      `CS_EXT_FALL: timer_clock = ext_fall;
      `CS_EXT_RISE: timer_clock = ext_rise;
      default:      timer_clock = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Counter unit: top, bottom, match and next value
  // ----------------------------------------------------------------
  wire mode_ctc = (waveform_mode == `WAVE_CTC);
  wire [7:0] top_value = mode_ctc ? compare_value_q : `COUNT_MAX;
  wire match = (counter_value_q == compare_value_q);

  assign at_bottom = (counter_value_q == `COUNT_BOTTOM);
  assign at_max    = (counter_value_q == `COUNT_MAX);
  assign at_top    = (counter_value_q == top_value);

  // Only up-counting modes are built; the down direction stays unused
  wire count_clear = mode_ctc && match;
  wire [7:0] count_next = count_clear ? `COUNT_BOTTOM :
                          counter_value_q + 8'h01;

  // Normal mode overflows as the counter wraps to zero; CTC at its top
  wire overflow_evt = timer_clock && !wr_cnt &&
                      (mode_ctc ? count_clear : at_max);
  wire compare_evt  = timer_clock && match && !block_match_q;

  // ----------------------------------------------------------------
  // Counter and blocking flag: a processor write wins over counting
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (rst) begin
      counter_value_q <= `RESET_BYTE;
      block_match_q   <= 1'b0;
    end else begin
      if (wr_cnt) begin
        counter_value_q <= pwdata[7:0];
      end else if (timer_clock) begin
        counter_value_q <= count_next;
      end
      if (wr_cnt) begin
        block_match_q <= 1'b1;
      end else if (timer_clock) begin
        block_match_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control, compare and mask registers
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (rst) begin
      timer_control_q <= 5'h00;
      compare_value_q <= `RESET_BYTE;
      irq_mask_q      <= 2'h0;
    end else begin
      if (wr_ctrl) begin
        timer_control_q <= pwdata[4:0];
      end
      if (wr_cmp) begin
        compare_value_q <= pwdata[7:0];
      end
      if (wr_mask) begin
        irq_mask_q <= pwdata[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Flags: write one to clear; a new event in the same cycle wins
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (rst) begin
      irq_flags_q <= 2'h0;
    end else begin
      irq_flags_q[`FLAG_OVF_BIT] <= overflow_evt ||
        (irq_flags_q[`FLAG_OVF_BIT] && !(wr_flags && pwdata[`FLAG_OVF_BIT]));
      irq_flags_q[`FLAG_CMP_BIT] <= compare_evt ||
        (irq_flags_q[`FLAG_CMP_BIT] && !(wr_flags && pwdata[`FLAG_CMP_BIT]));
    end
  end

  assign timer_irq = |(irq_flags_q & irq_mask_q);

  // ----------------------------------------------------------------
  // Read mux: registered so read data comes from flip-flops
  // ----------------------------------------------------------------
  reg [31:0] rdata_d;
  always @* begin
    case (paddr)
      `ADDR_SYNC_CONTROL:  rdata_d = {24'h00_0000, sync_hold_mode_q, 5'h00,
                                      async_psr_q, shared_psr_q};
      `ADDR_TIMER_CONTROL: rdata_d = {27'h000_0000, timer_control_q};
      `ADDR_COUNTER_VALUE: rdata_d = {24'h00_0000, counter_value_q};
      `ADDR_COMPARE_VALUE: rdata_d = {24'h00_0000, compare_value_q};
      `ADDR_IRQ_FLAGS:     rdata_d = {30'h0000_0000, irq_flags_q};
      `ADDR_IRQ_MASK:      rdata_d = {30'h0000_0000, irq_mask_q};
      default:             rdata_d = 32'h0000_0000;
    endcase
  end

  // Captured in setup so it is stable through the access phase
  always @(posedge ref_clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdata_d;
    end
  end

endmodule
`default_nettype wire

// ### verilog/timer8_defines.vh
// Register map, field positions, reset values and clock-select codes of the 8-bit timer
`ifndef TIMER8_DEFINES_VH
`define TIMER8_DEFINES_VH

// ----------------------------------------------------------------
// Register byte addresses on the APB bus
// ----------------------------------------------------------------
`define ADDR_SYNC_CONTROL   12'h000
`define ADDR_TIMER_CONTROL  12'h004
`define ADDR_COUNTER_VALUE  12'h008
`define ADDR_COMPARE_VALUE  12'h00C
`define ADDR_IRQ_FLAGS      12'h010
`define ADDR_IRQ_MASK       12'h014

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SYNC_HOLD_BIT       7
`define ASYNC_PSR_BIT       1
`define SHARED_PSR_BIT      0
`define WAVE_LO_BIT         0
`define WAVE_HI_BIT         1
`define CLKSEL_LSB          2
`define CLKSEL_MSB          4
`define FLAG_OVF_BIT        0
`define FLAG_CMP_BIT        1

// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define RESET_BYTE          8'h00
`define COUNT_BOTTOM        8'h00
`define COUNT_MAX           8'hFF

// ----------------------------------------------------------------
// Waveform and clock-select codes
// ----------------------------------------------------------------
`define WAVE_NORMAL         2'h0
`define WAVE_CTC            2'h2
`define CS_STOP             3'h0
`define CS_DIRECT           3'h1
`define CS_DIV8             3'h2
`define CS_DIV64            3'h3
`define CS_DIV256           3'h4
`define CS_DIV1024          3'h5
`define CS_EXT_FALL         3'h6
`define CS_EXT_RISE         3'h7
`define PRESCALE_WIDTH      10

`endif
